// ---- shared/cbcr_consts.svh ----
`ifndef CBCR_CONSTS_SVH
`define CBCR_CONSTS_SVH

// Counter width for link-clock edge counting
`define CBCR_CNT_W        8
`define CBCR_CNT_ZERO     8'h00
`define CBCR_CNT_ONE      8'h01
// Link edges after releasing clock-run before its level is trusted
`define CBCR_SETTLE_EDGES 8'h02
// Default link edges of advance notice before slowing or stopping
`define CBCR_ANN_EDGES    8'h08
// Default link rising edges per card clock half period when slowed
`define CBCR_SLOW_HALF    8'h04

`endif

// ---- shared/cbcr_pkg.sv ----
`default_nettype none
`include "cbcr_consts.svh"

package cbcr_pkg;

  // Gray codes along run -> announce -> low power
  typedef enum logic [1:0] {
    CBCR_RUN      = 2'h0,
    CBCR_ANNOUNCE = 2'h1,
    CBCR_LOWPWR   = 2'h3
  } cbcr_state_type;

  typedef struct packed {
    logic                     pciSync1;
    logic                     pciSync2;
    logic                     pciLast;
    logic                     runSync1;
    logic                     runSync2;
    cbcr_state_type           state;
    logic [`CBCR_CNT_W-1:0]   edgeCnt;
    logic [`CBCR_CNT_W-1:0]   divCnt;
    logic                     cardClk;
    logic                     cardClkRise;
    logic                     clkRunOe;
    logic                     cardRst_n;
    logic                     parkEn;
    logic                     clkReduced;
  } cbcr_regs_type;

endpackage : cbcr_pkg

`default_nettype wire

// ---- verilog/cbcr_clock_reset.sv ----
// Notes on behaviour
// RQ1: Card signals, except sideband lines, are sampled on card clock rising.
// RQ2: Card clock runs at host PCI clock frequency in normal operation.
// RQ3: Card clock may be halted low or slowed to save power.
// RQ4: Card pulls clock-run to ask for a faster clock.
// RQ5: Controller announces on clock-run before lowering clock frequency.
// RQ6: Card reset returns card registers and sequencers to initial state.
// RQ7: Card tristates all its CardBus signals while reset is asserted.
// RQ8: Controller parks card interface signals at valid levels during reset.
// RQ9: Controller may assert card reset at any moment.
// RQ10: Card reset deassertion is synchronous to the card clock.
// RQ11: Address/data lines carry 32-bit address then data, bit 31 MSB.
// RQ12: No slow-down while card requests speed; restore full speed promptly.
`include "cbcr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module cbcr_clock_reset
  import cbcr_pkg::*;
#(
  parameter logic [`CBCR_CNT_W-1:0] ANN_EDGES = `CBCR_ANN_EDGES,
  parameter logic [`CBCR_CNT_W-1:0] SLOW_HALF = `CBCR_SLOW_HALF
) (
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Host PCI clock, asynchronous to core_clk
  input  wire logic pciClk,
  // Power and reset requests from host logic
  input  wire logic lowPowerReq,
  input  wire logic slowNotStop,
  input  wire logic cardResetReq,
  // Card clock and reset pins
  output logic      cardClk,
  output logic      cardRst_n,
  // Clock-run pin, active low, open drain
  input  wire logic clkRunIn_n,
  output logic      clkRunOut_n,
  output logic      clkRunOe,
  // Status towards the interface logic
  output logic      cardClkRise,
  output logic      parkEn,
  output logic      clkReduced
);

  cbcr_regs_type s;
  cbcr_regs_type next_s;
  logic          pciRise;
  logic          cardAsks;
  logic          settled;

  always_comb begin
    next_s = s;
    // Two flops per pin input, plus a third edge flop on the PCI clock; the first flop never feeds logic
    next_s.pciSync1 = pciClk;
    next_s.pciSync2 = s.pciSync1;
    next_s.pciLast  = s.pciSync2;
    next_s.runSync1 = clkRunIn_n;
    next_s.runSync2 = s.runSync1;
    pciRise  = s.pciSync2 & ~s.pciLast;
    settled  = s.edgeCnt >= `CBCR_SETTLE_EDGES;
    // Only meaningful while the controller has let go of the pin
    cardAsks = ~s.clkRunOe & ~s.runSync2 & settled;

    case (s.state)
      CBCR_RUN: begin
        next_s.clkRunOe = 1'b1;
        next_s.edgeCnt  = `CBCR_CNT_ZERO;
        // Reset must see a running clock to be released
        if (lowPowerReq && !cardResetReq && s.cardRst_n) begin // see RQ5
          next_s.state    = CBCR_ANNOUNCE;
          next_s.clkRunOe = 1'b0;
        end
      end
      CBCR_ANNOUNCE: begin
        if (pciRise && s.edgeCnt != ANN_EDGES) begin
          next_s.edgeCnt = s.edgeCnt + `CBCR_CNT_ONE;
        end
        if (cardAsks || !lowPowerReq || cardResetReq) begin // see RQ12
          next_s.state    = CBCR_RUN;
          next_s.clkRunOe = 1'b1;
        end else if (s.edgeCnt == ANN_EDGES) begin // see RQ5
          next_s.state  = CBCR_LOWPWR;
          next_s.divCnt = `CBCR_CNT_ZERO;
        end
      end
      CBCR_LOWPWR: begin
        if (cardAsks || !lowPowerReq || cardResetReq) begin // see RQ12
          next_s.state    = CBCR_RUN;
          next_s.clkRunOe = 1'b1;
        end
      end
      default: begin
        next_s.state    = CBCR_RUN;
        next_s.clkRunOe = 1'b1;
      end
    endcase

    // Card clock generation; full speed follows the PCI clock phase
    if (s.state != CBCR_LOWPWR) begin
      next_s.cardClk = s.pciSync2; // see RQ2
    end else if (!slowNotStop) begin
      // Finish any high phase, then park low
      next_s.cardClk = s.cardClk & s.pciSync2; // see RQ3
    end else if (pciRise) begin
      if (s.divCnt >= SLOW_HALF - `CBCR_CNT_ONE) begin // see RQ3
        next_s.divCnt  = `CBCR_CNT_ZERO;
        next_s.cardClk = ~s.cardClk;
      end else begin
        next_s.divCnt = s.divCnt + `CBCR_CNT_ONE;
      end
    end
    next_s.clkReduced  = next_s.state == CBCR_LOWPWR;
    // Interface logic samples card inputs on this strobe
    next_s.cardClkRise = next_s.cardClk & ~s.cardClk; // see RQ1

    // Assert at once, release only on a card clock falling edge
    if (cardResetReq) begin
      next_s.cardRst_n = 1'b0; // see RQ9
    end else if (!s.cardRst_n && s.cardClk && !next_s.cardClk) begin
      next_s.cardRst_n = 1'b1; // see RQ10
    end
    next_s.parkEn = ~next_s.cardRst_n; // see RQ8
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{state: CBCR_RUN, runSync1: 1'b1, runSync2: 1'b1,
             clkRunOe: 1'b1, parkEn: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign cardClk     = s.cardClk;
  assign cardRst_n   = s.cardRst_n;
  assign clkRunOut_n = 1'b0;
  assign clkRunOe    = s.clkRunOe;
  assign cardClkRise = s.cardClkRise;
  assign parkEn      = s.parkEn;
  assign clkReduced  = s.clkReduced;

  // Checks stay idle while the core is in reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_park_in_reset: assert property ( // see RQ8
    !s.cardRst_n |-> s.parkEn)
    else $error("Card signals not parked during reset");

  a_reset_assert_fast: assert property ( // see RQ9
    cardResetReq |=> !s.cardRst_n)
    else $error("Card reset not asserted one cycle after request");

  a_reset_release_sync: assert property ( // see RQ10
    $rose(s.cardRst_n) |-> $fell(s.cardClk))
    else $error("Card reset released off a card clock edge");

  a_full_speed_follow: assert property ( // see RQ2
    (s.state == CBCR_RUN) ##1 (s.state == CBCR_RUN)
      |-> s.cardClk == $past(s.pciSync2))
    else $error("Card clock not following PCI clock at full speed");

  a_stop_low_hold: assert property ( // see RQ3
    (s.state == CBCR_LOWPWR && !slowNotStop && !s.cardClk)
      ##1 (s.state == CBCR_LOWPWR && !$past(slowNotStop)) |-> !s.cardClk)
    else $error("Stopped card clock left the low state");

  a_announce_first: assert property ( // see RQ5
    (s.state == CBCR_LOWPWR) && $changed(s.state)
      |-> $past(s.state) == CBCR_ANNOUNCE && !$past(s.clkRunOe))
    else $error("Clock lowered without clock-run notice");

  a_card_request_wins: assert property ( // see RQ12
    (s.state != CBCR_RUN) && !s.clkRunOe && !s.runSync2
      && s.edgeCnt >= `CBCR_SETTLE_EDGES |=> s.state == CBCR_RUN && s.clkRunOe)
    else $error("Card speed request not honoured next cycle");

  a_rise_strobe: assert property ( // see RQ1
    s.cardClkRise |-> s.cardClk && !$past(s.cardClk))
    else $error("Sample strobe not on card clock rising edge");

  // Bounds and converses that catch a broken counter, strobe, clock-run pin, wake or reset release
  a_rise_every_edge: assert property ( // see RQ1
    $rose(s.cardClk) |-> s.cardClkRise)
    else $error("Card clock rose without a sample strobe");

  a_run_holds_pin: assert property ( // see RQ5
    s.state == CBCR_RUN |-> s.clkRunOe)
    else $error("Clock-run released while at full speed");

  a_announce_releases: assert property ( // see RQ5
    s.state == CBCR_ANNOUNCE |-> !s.clkRunOe)
    else $error("Clock-run still driven during the notice");

  a_notice_count_bound: assert property ( // see RQ5
    s.edgeCnt <= ANN_EDGES)
    else $error("Notice counter ran past its limit");

  a_slow_divider_bound: assert property ( // see RQ3
    s.state == CBCR_LOWPWR |-> s.divCnt < SLOW_HALF)
    else $error("Slow divider ran past its half period");

  a_wake_full_speed: assert property ( // see RQ12
    (s.state == CBCR_LOWPWR) ##1 (s.state == CBCR_RUN)
      |=> s.cardClk == $past(s.pciSync2))
    else $error("Card clock not back to full speed after wake");

  a_reset_clock_runs: assert property ( // see RQ10
    !s.cardRst_n |-> s.state != CBCR_LOWPWR)
    else $error("Card clock lowered while card reset is held");

  a_release_after_req: assert property ( // see RQ10
    $rose(s.cardRst_n) |-> !$past(cardResetReq))
    else $error("Card reset released while still requested");

endmodule : cbcr_clock_reset

`default_nettype wire

// ---- verification/cbcr_card_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module cbcr_card_model (
  // Card reset pin
  input  wire logic cardRst_n,
  // Scenario control
  input  wire logic wantSpeed,
  // Pulls the clock-run wire low
  output logic      cardPull
);
  // Pulls even with the clock stopped; lets go in reset
  assign cardPull = cardRst_n & wantSpeed;
endmodule // cbcr_card_model

`default_nettype wire

// ---- verification/cardbus_clock_reset_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module cardbus_clock_reset_control_test;
  logic coreClk = 1'b0, arstN = 1'b0, pciClk = 1'b0, lowPowerReq = 1'b0;
  logic slowNotStop = 1'b0, cardResetReq = 1'b1, wantSpeed = 1'b0;
  wire  cardClk, cardRst_n, clkRunOut_n, clkRunOe, cardClkRise;
  wire  parkEn, clkReduced, cardPull;
  int   errorCnt = 0, checksDone = 0, cycles = 0;
  logic [7:0] n;
  // Open-drain wire with pull-up
  wire  clkRun_n = ((clkRunOe & ~clkRunOut_n) | cardPull) ? 1'b0 : 1'b1;

  always #2 coreClk = ~coreClk;
  always #62.5 pciClk = ~pciClk;

  cbcr_clock_reset #(.ANN_EDGES(8'h08), .SLOW_HALF(8'h04)) dut (
    .core_clk(coreClk), .arst_n(arstN), .pciClk(pciClk),
    .lowPowerReq(lowPowerReq), .slowNotStop(slowNotStop),
    .cardResetReq(cardResetReq), .cardClk(cardClk), .cardRst_n(cardRst_n),
    .clkRunIn_n(clkRun_n), .clkRunOut_n(clkRunOut_n), .clkRunOe(clkRunOe),
    .cardClkRise(cardClkRise), .parkEn(parkEn), .clkReduced(clkReduced));
  cbcr_card_model card (.cardRst_n(cardRst_n), .wantSpeed(wantSpeed),
    .cardPull(cardPull));

  task summarize;
    $display("comparisons %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  // Sampled at falling edges, where the pulse has settled
  task countRises(input int cyc);
    n = 8'h00;
    repeat (cyc) begin
      @(negedge coreClk);
      n = n + {7'h00, cardClkRise};
    end
  endtask

  task waitReduced(input logic lvl);
    for (int i = 0; i < 400 && clkReduced !== lvl; i++) @(negedge coreClk);
  endtask

  task testReset;
    @(negedge coreClk);
    check({clkRun_n, clkRunOe, parkEn, cardRst_n}, 8'h06);
    cardResetReq = 1'b0;
    for (int i = 0; i < 100 && cardRst_n !== 1'b1; i++) @(negedge coreClk);
    check({cardRst_n, cardClk, parkEn}, 8'h04);
    cardResetReq = 1'b1;
    @(negedge coreClk);
    check({cardRst_n, parkEn}, 8'h01);
    cardResetReq = 1'b0;
    for (int i = 0; i < 100 && cardRst_n !== 1'b1; i++) @(negedge coreClk);
    check({cardRst_n, cardClk}, 8'h02);
    $display("reset test done");
  endtask

  task testFull;
    countRises(500);
    check(8'(n >= 8'h0f && n <= 8'h11), 8'h01);
    $display("full speed test done");
  endtask

  task testStop;
    lowPowerReq = 1'b1;
    slowNotStop = 1'b0;
    @(negedge coreClk);
    @(negedge coreClk);
    check({clkRun_n, clkRunOe, clkReduced}, 8'h04);
    waitReduced(1'b1);
    countRises(300);
    check({clkReduced, cardClk}, 8'h02);
    check(n, 8'h00);
    wantSpeed = 1'b1;
    // Two sync flops, then one state step
    repeat (3) @(negedge coreClk);
    check({clkRunOe, clkReduced}, 8'h02);
    // Retries re-announce, but the held request keeps full speed
    countRises(300);
    check(8'(n >= 8'h09 && n <= 8'h0a && !clkReduced), 8'h01);
    lowPowerReq = 1'b0;
    countRises(100);
    wantSpeed = 1'b0;
    check(8'(!clkReduced && n > 8'h01), 8'h01);
    $display("stop test done");
  endtask

  task testSlow;
    lowPowerReq = 1'b1;
    slowNotStop = 1'b1;
    waitReduced(1'b1);
    countRises(1000);
    // Slow period is twice SLOW_HALF PCI periods, 1000 ns
    check(n, 8'h04);
    lowPowerReq = 1'b0;
    repeat (3) @(negedge coreClk);
    check({clkRunOe, clkReduced}, 8'h02);
    $display("slow test done");
  endtask

  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 20000) begin
      errorCnt++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(negedge coreClk);
    arstN = 1'b1;
    testReset();
    testFull();
    testStop();
    testSlow();
    summarize();
  end
endmodule // cardbus_clock_reset_control_test

`default_nettype wire
